// >>> logic/sp_host.sv
// Host controller driving the shared mode and transmit pins of the device
//
// Rules from the document
// [R01] Mode pin falls, transmit held high: standby
// [R02] Mode pin rising edge returns device to normal
// [R03] Falling mode edge acts whatever transceiver state
// [R04] Mode low, then transmit falls within window
// [R05] Serial mode: mode clocks, transmit carries data
// [R06] Outside serial mode transmit level drives bus
// [R07] Device blocks sending in sleep, shutdown, reset
// [R08] Device passes debounced bus level to receive
// [R09] Over-temperature resets device, transceiver recessive
// [R10] No wake-up during thermal shutdown
// [R11] Device reinitializes fully after temperature recovers
// [R12] Low-slew setting reverts; host reselects it
// [R13] Frame: command byte then whole data bytes
// [R14] Command: direction, two length bits, address
// [R15] Direction zero writes, one reads
// [R16] Length code gives one, two, four, eight
// [R17] Single-byte transfer ends serial mode
// [R18] Later bytes go to next address
// [R19] All fields sent most significant bit first
// [R20] Write bits driven on rise, sampled falling
// [R21] Command bits driven on rise, sampled falling
// [R22] Read data driven on rise, host samples falling
// [R23] Register space is 32 bytes
// [R24] Multi-byte transfer also ends serial mode
// [R25] Data line turns after address, back after
`timescale 1ns/10ps
`default_nettype none
`include "sp_host_params.svh"

module sp_host
    import sp_host_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Mode pin, serial clock in serial mode
    output logic mode_o,
    // Transmit pin, serial data in serial mode
    input wire logic tx_i,
    output logic tx_o,
    output logic tx_oe,
    // Receive pin from the device
    input wire logic rx_i
);

    host_regs_t r;
    host_regs_t n;
    logic tick;
    logic sck_run;
    logic wr_take;
    logic rd_take;
    logic busy;
    logic is_read;
    logic [3:0] nbytes;
    logic [6:0] last_bit;
    logic [5:0] data_idx;

    // Serial clock half-period ticks, only while shifting; the divider
    // restarts per frame, so the first half period is full length
    assign sck_run = (r.state == ST_SP_SHIFT);

    sp_tick_div u_div (
        .clk(clk),
        .srst(srst),
        .run(sck_run),
        .tick(tick)
    );

    // APB strobes; pready comes one cycle into the access phase
    // Writes act only at the edge where pready is seen high
    assign rd_take = psel & penable & ~r.pready & ~pwrite;
    assign wr_take = psel & penable & r.pready & pwrite;
    // Standby is not busy: software may wake the device at any time
    assign busy = (r.state != ST_NORMAL) && (r.state != ST_STANDBY);

    // Data bytes in a frame for a length code; a table rather than a shift
    // so it reads the same as the command byte layout
    function automatic logic [3:0] frame_bytes(input logic [1:0] code);
        logic [3:0] count;
        case (code)
            2'b00: begin
                count = 4'h1;
            end
            2'b01: begin
                count = 4'h2;
            end
            2'b10: begin
                count = 4'h4;
            end
            default: begin
                count = 4'h8;
            end
        endcase
        return count;
    endfunction : frame_bytes

    // Wire position of a data bit: byte k sits at bits 8k+7..8k of the
    // 64-bit buffer and leaves the pin MSB first; the byte number is cut
    // to three bits on purpose, the count never passes byte 7
    function automatic logic [5:0] data_bit(input logic [6:0] cnt);
        logic [2:0] byte_no;
        byte_no = 3'(cnt[6:3] - 4'h1);
        return {byte_no, ~cnt[2:0]};
    endfunction : data_bit

    // Frame geometry from the latched command byte; the command is frozen
    // while busy, so these stay steady for the whole frame
    assign is_read = r.cmd[`CMD_DIR]; // R15
    assign nbytes = frame_bytes({r.cmd[`CMD_LEN_HI],
        r.cmd[`CMD_LEN_LO]}); // R16
    assign last_bit = {nbytes, 3'b111}; // R13
    assign data_idx = data_bit(r.bit_cnt); // R19

    always_comb begin
        n = r;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        n.prdata = 32'h0000_0000; // Read data stands only beside pready

        // Two-stage synchronisers on the pins from the device
        // Read bits reach tx_sync[1] three cycles after the rising edge,
        // one inside the four-cycle half period: the divider must not shrink
        n.tx_sync = {r.tx_sync[0], tx_i};
        n.rx_sync = {r.rx_sync[0], rx_i};

        // Read answer prepared together with pready
        // Unmapped or misaligned offsets answer with pslverr and no data
        if (psel & penable & ~r.pready) begin
            n.pready = 1'b1;
            n.prdata = 32'h0000_0000;
            case (paddr)
                `REG_CTRL: begin
                    n.prdata[`CTRL_TX_LEVEL] = r.tx_level;
                end
                `REG_CMD: begin
                    n.prdata[7:0] = r.cmd;
                end
                `REG_WDATA_LO: begin
                    n.prdata = r.wdata[31:0];
                end
                `REG_WDATA_HI: begin
                    n.prdata = r.wdata[63:32];
                end
                `REG_RDATA_LO: begin
                    n.prdata = r.rdata[31:0];
                end
                `REG_RDATA_HI: begin
                    n.prdata = r.rdata[63:32];
                end
                `REG_STATUS: begin
                    n.prdata[`STAT_BUSY] = busy;
                    n.prdata[`STAT_DONE] = r.done;
                    n.prdata[`STAT_STANDBY] = (r.state == ST_STANDBY);
                    n.prdata[`STAT_RX] = r.rx_sync[1];
                    n.prdata[`STAT_TX_PIN] = r.tx_sync[1];
                end
                default: begin
                    n.pslverr = 1'b1;
                end
            endcase
            if (!rd_take) begin
                n.prdata = 32'h0000_0000;
            end
        end

        // Register writes land at the edge where pready is seen high;
        // frame setup is frozen while a sequence runs
        if (wr_take) begin
            case (paddr)
                `REG_CTRL: begin
                    // Level is kept always; it reaches the pin in normal only
                    n.tx_level = pwdata[`CTRL_TX_LEVEL];
                end
                `REG_CMD: begin
                    // Frame setup stays open between frames, so software
                    // can restore device settings lost to a restart
                    if (!busy) begin // R12
                        n.cmd = pwdata[7:0];
                    end
                end
                `REG_WDATA_LO: begin
                    if (!busy) begin
                        n.wdata[31:0] = pwdata;
                    end
                end
                `REG_WDATA_HI: begin
                    if (!busy) begin
                        n.wdata[63:32] = pwdata;
                    end
                end
                `REG_STATUS: begin
                    // A frame ending in this cycle sets done again: set wins
                    if (pwdata[`STAT_DONE]) begin
                        n.done = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Pin sequencer
        case (r.state)
            ST_NORMAL: begin
                n.mode_o = 1'b1;
                n.tx_oe = 1'b1;
                n.tx_o = r.tx_level; // R06
                if (wr_take && paddr == `REG_CTRL) begin
                    // Start wins if standby is asked for in the same write
                    if (pwdata[`CTRL_START]) begin
                        // Mode falls with transmit high, then a quick
                        // transmit fall marks serial entry
                        n.mode_o = 1'b0;
                        n.tx_o = 1'b1;
                        n.timer = 16'h0000;
                        n.state = ST_SP_ENTRY;
                    end else if (pwdata[`CTRL_STANDBY]) begin
                        n.mode_o = 1'b0; // R03
                        n.tx_o = 1'b1;
                        n.timer = 16'h0000;
                        n.state = ST_STBY_HOLD;
                    end
                end
            end
            ST_STBY_HOLD: begin
                // Transmit held high for the standby trigger time;
                // a fall inside the entry window would start a frame instead
                n.tx_o = 1'b1; // R01
                if (r.timer == 16'(`STANDBY_TRIGGER_CYC - 1)) begin
                    n.state = ST_STANDBY;
                end else begin
                    n.timer = r.timer + 16'h0001;
                end
            end
            ST_STANDBY: begin
                // Wake-up may be ignored by a device in thermal shutdown
                n.tx_o = 1'b1;
                if (wr_take && paddr == `REG_CTRL && pwdata[`CTRL_WAKE]) begin
                    n.mode_o = 1'b1; // R02
                    n.state = ST_NORMAL;
                end
            end
            ST_SP_ENTRY: begin
                // Drop transmit at half the window so slack stays both ways
                // Timer counts from the edge at which the mode pin fell
                if (r.timer == 16'(`SERIAL_ENTRY_CYC - 1)) begin
                    n.tx_o = 1'b0; // R04
                    n.phase = 1'b0;
                    n.bit_cnt = 7'h00;
                    n.state = ST_SP_SHIFT;
                end else begin
                    n.timer = r.timer + 16'h0001;
                end
            end
            ST_SP_SHIFT: begin
                if (tick && !r.phase) begin
                    // Rising serial clock: present the next bit
                    n.mode_o = 1'b1; // R05
                    n.phase = 1'b1;
                    if (r.bit_cnt < 7'd8) begin
                        n.tx_oe = 1'b1;
                        n.tx_o = r.cmd[~r.bit_cnt[2:0]]; // R14 R21
                    end else if (is_read) begin
                        // Both ends let go for a cycle; the pull-up holds it
                        n.tx_oe = 1'b0; // R25
                    end else begin
                        n.tx_oe = 1'b1;
                        n.tx_o = r.wdata[data_idx]; // R20 R18
                    end
                end else if (tick && r.phase) begin
                    // Falling serial clock: device samples, host reads
                    n.mode_o = 1'b0;
                    n.phase = 1'b0;
                    if (is_read && r.bit_cnt >= 7'd8) begin
                        n.rdata[data_idx] = r.tx_sync[1]; // R22
                    end
                    if (r.bit_cnt == last_bit) begin
                        n.timer = 16'h0000;
                        n.state = ST_SP_EXIT;
                    end else begin
                        n.bit_cnt = r.bit_cnt + 7'h01;
                    end
                end
            end
            ST_SP_EXIT: begin
                // Device has left serial mode; line back to transmit use
                // Mode stays low a half period so the last fall stands full
                n.tx_oe = 1'b1; // R24 R17
                n.tx_o = 1'b1;
                if (r.timer == 16'(`SCK_HALF_CYC - 1)) begin
                    n.mode_o = 1'b1;
                    n.state = ST_NORMAL;
                    n.done = 1'b1;
                end else begin
                    n.timer = r.timer + 16'h0001;
                end
            end
            default: begin
                n.state = ST_NORMAL;
            end
        endcase
    end

    // Single register stage for all state
    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
            r.state <= ST_NORMAL;
            r.mode_o <= 1'b1;
            r.tx_o <= `TX_LEVEL_RESET;
            r.tx_oe <= 1'b1;
            r.tx_level <= `TX_LEVEL_RESET;
            r.cmd <= `CMD_RESET;
            // Bus answer and frame counters start cleared
            r.pready <= 1'b0;
            r.pslverr <= 1'b0;
            r.prdata <= 32'h0000_0000;
            r.done <= 1'b0;
            r.timer <= 16'h0000;
            r.bit_cnt <= 7'h00;
            r.phase <= 1'b0;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the register stage
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign mode_o = r.mode_o;
    assign tx_o = r.tx_o;
    assign tx_oe = r.tx_oe;

endmodule : sp_host
`default_nettype wire

// >>> logic/sp_host_params.svh
// Offsets, field positions, reset values and timing counts of the host
`ifndef SP_HOST_PARAMS_SVH
`define SP_HOST_PARAMS_SVH

// Clock and link timing
`define CLK_PERIOD_NS 10
`define SCK_HALF_CYC 4
`define STANDBY_TRIGGER_TIME_NS 20000
`define STANDBY_TRIGGER_CYC \
    ((`STANDBY_TRIGGER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SERIAL_ENTRY_WINDOW_NS 1000
`define SERIAL_ENTRY_CYC ((`SERIAL_ENTRY_WINDOW_NS / `CLK_PERIOD_NS) / 2)

// APB register offsets
`define APB_AW 8
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_WDATA_LO 8'h08
`define REG_WDATA_HI 8'h0C
`define REG_RDATA_LO 8'h10
`define REG_RDATA_HI 8'h14
`define REG_STATUS 8'h18

// Control register bits
`define CTRL_START 0
`define CTRL_STANDBY 1
`define CTRL_WAKE 2
`define CTRL_TX_LEVEL 3
`define TX_LEVEL_RESET 1'b1

// Command byte fields
`define CMD_DIR 7
`define CMD_LEN_HI 6
`define CMD_LEN_LO 5
`define CMD_ADDR_HI 4
`define CMD_RESET 8'h00

// Status register bits
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_STANDBY 2
`define STAT_RX 3
`define STAT_TX_PIN 4

`endif

// >>> logic/sp_host_pkg.sv
// Types shared by the serial-port host and its tick divider
`include "sp_host_params.svh"

package sp_host_pkg;

    typedef enum logic [2:0] {
        ST_NORMAL,
        ST_STBY_HOLD,
        ST_STANDBY,
        ST_SP_ENTRY,
        ST_SP_SHIFT,
        ST_SP_EXIT
    } host_state_t;

    typedef struct packed {
        host_state_t state;
        logic [15:0] timer;
        logic phase;
        logic [6:0] bit_cnt;
        logic [7:0] cmd;
        logic [63:0] wdata;
        logic [63:0] rdata;
        logic tx_level;
        logic done;
        logic mode_o;
        logic tx_o;
        logic tx_oe;
        logic [1:0] tx_sync;
        logic [1:0] rx_sync;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } host_regs_t;

    typedef struct packed {
        logic [7:0] count;
        logic tick;
    } div_regs_t;

endpackage : sp_host_pkg

// >>> logic/sp_tick_div.sv
// Half-period tick divider for the serial clock
`timescale 1ns/10ps
`default_nettype none
`include "sp_host_params.svh"

module sp_tick_div
    import sp_host_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Control and tick
    input wire logic run,
    output logic tick
);

    div_regs_t r;
    div_regs_t n;

    // Count while running; restart from zero when stopped
    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (!run) begin
            n.count = 8'h00;
        end else if (r.count == 8'(`SCK_HALF_CYC - 1)) begin
            n.count = 8'h00;
            n.tick = 1'b1;
        end else begin
            n.count = r.count + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;

endmodule : sp_tick_div
`default_nettype wire

// >>> sim/sp_dev_model.sv
// Behavioural device behind the shared mode and transmit pins
`timescale 1ns/10ps
`default_nettype none

module sp_dev_model (
    // Sampling clock
    input wire logic clk,
    // Shared pins
    input wire logic mode_pin,
    input wire logic tx_pin,
    output logic dev_oe,
    output logic dev_o,
    // Receive pin
    output logic rx_o,
    // Over-temperature condition, set by the bench
    input wire logic hot
);
    logic [7:0] mem [32];
    logic [7:0] cmd = 8'h00;
    logic [7:0] sh = 8'h00;
    logic mode_q = 1'b1;
    logic tx_q = 1'b1;
    logic sp_mode = 1'b0;
    logic standby = 1'b0;
    logic hot_q = 1'b0;
    logic [4:0] at;
    int low_cnt = 0;
    int nbit = 0;
    int last;

    initial begin
        dev_oe = 1'b0;
        dev_o = 1'b1;
        for (int i = 0; i < 32; i++) mem[i] = 8'h00;
    end
    // Bus copies transmit only in normal mode; recessive reads high
    assign rx_o = sp_mode | standby | hot | tx_pin;
    assign last = 8 * (1 << cmd[6:5]) + 7;
    assign at = cmd[4:0] + 5'((nbit - 8) / 8);

    // Pin edges are seen on the sampling clock
    always @(posedge clk) begin
        mode_q <= mode_pin;
        tx_q <= tx_pin;
        low_cnt <= mode_pin ? 0 : low_cnt + 1;
        hot_q <= hot;
        if (hot) begin
            // Shut down: transceiver off, pin requests ignored
            sp_mode <= 1'b0;
            dev_oe <= 1'b0;
            standby <= 1'b1;
        end else if (hot_q) begin
            // Cooled down: full restart whatever the pins show
            standby <= 1'b0;
            for (int i = 0; i < 32; i++) mem[i] <= 8'h00;
        end else if (!sp_mode) begin
            if (!mode_pin && tx_q && !tx_pin && low_cnt < 100) begin
                sp_mode <= 1'b1;
                nbit <= 0;
            end
            if (!mode_pin && tx_pin && low_cnt >= 2000) standby <= 1'b1;
            if (mode_pin && !mode_q) standby <= 1'b0;
        end else if (mode_pin && !mode_q && cmd[7] && nbit >= 8) begin
            dev_oe <= 1'b1;
            dev_o <= mem[at][7 - nbit % 8];
        end else if (!mode_pin && mode_q) begin
            // Falling edge: take the bit on the line
            nbit <= nbit + 1;
            sh <= {sh[6:0], tx_pin};
            if (nbit < 8) begin
                cmd <= {cmd[6:0], tx_pin};
            end else if (!cmd[7] && nbit % 8 == 7) begin
                mem[at] <= {sh[6:0], tx_pin};
            end
            if (nbit == last) begin
                sp_mode <= 1'b0;
                dev_oe <= 1'b0;
            end
        end
    end
endmodule : sp_dev_model

`default_nettype wire

// >>> sim/sp_host_bench.sv
// Self-checking bench for the serial-port host
`timescale 1ns/10ps
`default_nettype none
`include "sp_host_params.svh"

module sp_host_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic hot = 1'b0;
    logic [31:0] prdata, r;
    logic pready, pslverr, mode_o, tx_o, tx_oe, tx_w, dev_oe, dev_o, rx, e;
    logic [63:0] pat, got;
    int n_errors = 0;
    int checks_done = 0;
    int cyc = 0;

    always #5 clk = ~clk;
    // Shared data pin; pulled up when nobody drives it
    assign tx_w = tx_oe ? tx_o : (dev_oe ? dev_o : 1'b1);

    sp_host dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_o(mode_o), .tx_i(tx_w),
        .tx_o(tx_o), .tx_oe(tx_oe), .rx_i(rx));
    sp_dev_model dev (.clk(clk), .mode_pin(mode_o), .tx_pin(tx_w),
        .dev_oe(dev_oe), .dev_o(dev_o), .rx_o(rx), .hot(hot));

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            n_errors++;
            $display("MISMATCH %0t got %h want %h", $time, g, x);
        end
    endtask : chk

    // One APB transfer; waits up to 20 cycles for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk({31'h0000_0000, pready}, 32'h0000_0001);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Poll for frame end, then clear the sticky flag
    task automatic wait_done;
        for (int i = 0; i < 400 && r[`STAT_DONE] !== 1'b1; i++) begin
            apb(1'b0, `REG_STATUS, 32'h0);
        end
        chk(r & 32'h0000_0003, 32'h0000_0002);
        apb(1'b1, `REG_STATUS, 32'h0000_0002);
    endtask : wait_done

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin : main
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        chk({29'h0, mode_o, tx_o, tx_oe}, 32'h0000_0007);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(r, 32'h0000_0018);
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, e}, 32'h0000_0001);
        // Every length code: write a block, read it back
        for (int rd = 0; rd < 2; rd++) begin
            for (int c = 0; c < 4; c++) begin
                pat = 64'hF1E2_D3C4_B5A6_9788 + 64'(c);
                apb(1'b1, `REG_CMD, {24'h0, 1'(rd), 2'(c), 5'(c * 8)});
                apb(1'b1, `REG_WDATA_LO, pat[31:0]);
                apb(1'b1, `REG_WDATA_HI, pat[63:32]);
                apb(1'b1, `REG_CTRL, 32'h0000_0009);
                apb(1'b0, `REG_STATUS, 32'h0);
                chk(r & 32'h1, 32'h1);
                wait_done();
                apb(1'b0, `REG_RDATA_LO, 32'h0);
                got[31:0] = r;
                apb(1'b0, `REG_RDATA_HI, 32'h0);
                got[63:32] = r;
                for (int k = 0; k < 8; k++) begin
                    if (rd == 0) begin
                        chk({24'h0, dev.mem[c * 8 + k]},
                            k < (1 << c) ? {24'h0, pat[8 * k +: 8]} : 32'h0);
                    end else if (k < (1 << c)) begin
                        chk(got[8 * k +: 8], pat[8 * k +: 8]);
                    end
                end
            end
        end
        // Transmit level reaches the bus in normal mode; then standby entry and wake
        apb(1'b1, `REG_CTRL, 32'h0);
        repeat (4) @(posedge clk);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(r & 32'h18, 32'h0);
        apb(1'b1, `REG_CTRL, 32'h0000_000A);
        for (int i = 0; i < 1000 && r[`STAT_STANDBY] !== 1'b1; i++) begin
            apb(1'b0, `REG_STATUS, 32'h0);
        end
        repeat (10) @(posedge clk);
        chk({31'h0, dev.standby}, 32'h1);
        apb(1'b1, `REG_CTRL, 32'h0000_000C);
        repeat (4) @(posedge clk);
        chk({30'h0, dev.standby, mode_o}, 32'h1);
        // Over-temperature: bus recessive, wake ignored, full restart
        hot <= 1'b1;
        apb(1'b1, `REG_CTRL, 32'h0000_0002);
        for (int i = 0; i < 1000 && r[`STAT_STANDBY] !== 1'b1; i++) begin
            apb(1'b0, `REG_STATUS, 32'h0);
        end
        apb(1'b1, `REG_CTRL, 32'h0000_0004);
        repeat (4) @(posedge clk);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(r & 32'h1C, 32'h08);
        chk({31'h0, dev.standby}, 32'h1);
        hot <= 1'b0;
        repeat (4) @(posedge clk);
        chk({31'h0, dev.standby}, 32'h0);
        chk({24'h0, dev.mem[0]}, 32'h0);
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(r & 32'h18, 32'h0);
        close_out();
    end
endmodule : sp_host_bench

`default_nettype wire

// >>> sim/sp_host_monitor.sv
// Port checks for the serial-port host
`timescale 1ns/10ps
`default_nettype none
`include "sp_host_params.svh"

module sp_host_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [`APB_AW-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Device pins
    input wire logic mode_o,
    input wire logic tx_o,
    input wire logic tx_oe
);
    logic [15:0] low_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // Cycles the mode pin has been low, saturating
    always_ff @(posedge clk) begin
        if (srst || mode_o) begin
            low_cnt <= 16'h0000;
        end else if (low_cnt != 16'hFFFF) begin
            low_cnt <= low_cnt + 16'h0001;
        end
    end

    apb_wait_a: assert property (psel && $rose(penable) |=> pready)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_decode_a: assert property (pready && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > 8'h18)) else $error("bad pslverr");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata outside answer");
    entry_window_a: assert property (
        $fell(tx_o) && tx_oe && !mode_o |-> low_cnt < 16'h0064)
        else $error("data fell outside entry window");
    clk_low_a: assert property ($fell(mode_o) |-> !mode_o [*4])
        else $error("serial clock low phase short");
    turn_a: assert property ($fell(tx_oe) |-> $rose(mode_o))
        else $error("data line turned off a rising edge");
    read_hold_a: assert property (!tx_oe && $rose(mode_o) |-> mode_o [*4])
        else $error("read bit high phase short");
    return_a: assert property ($rose(tx_oe) |-> tx_o && !mode_o)
        else $error("data line returned wrongly");
    reset_pins_a: assert property (disable iff (1'b0)
        srst |=> mode_o && tx_o && tx_oe) else $error("pins not idle in reset");
endmodule : sp_host_monitor

bind sp_host sp_host_monitor u_mon (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_o(mode_o), .tx_o(tx_o), .tx_oe(tx_oe));

`default_nettype wire
